// File: mac_link_model.sv
// far-side model: the mac across the sgmii link, raising alignment errors
// assumes: same clock as the register bank; one pulse per request
`timescale 1ns/10ps
module mac_link_model
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic misalign_req,
  output logic      align_err_evt
);
  // offset kept inside the tightest jumbo bound, arbitrary value
  localparam int ppm_offset = 50;
  // ------------------------------------------------------------
  // error pulse
  // ------------------------------------------------------------
  // one clock wide; a held request repeats the pulse every second clock
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn) align_err_evt <= 1'b0;
    else       align_err_evt <= misalign_req && !align_err_evt;
  end
endmodule  // mac_link_model

// File: phy_ctl_pkg.sv
// package: register offsets, field positions, reset values and codes
// assumes: a 32-bit apb slave with 16-bit registers in the low bits
package phy_ctl_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ctl_one_addr    = 8'h14;  // first extended control
  localparam logic [7:0] ctl_two_addr    = 8'h18;  // second extended control
  localparam logic [7:0] reset_addr      = 8'h00;  // control, soft reset bit
  localparam logic [7:0] irq_stat_addr   = 8'h40;
  localparam logic [7:0] irq_en_addr     = 8'h44;
  localparam logic [7:0] irq_clr_addr    = 8'h48;
  localparam logic [7:0] link_stat_addr  = 8'h4C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int soft_reset_bit  = 15;
  localparam int mode_lo         = 8;
  localparam int align_err_bit   = 1;
  localparam int edge_lo         = 13;
  localparam int low_power_bit   = 12;
  localparam int in_pre_lo       = 7;
  localparam int out_pre_bit     = 6;
  localparam int jumbo_lo        = 4;
  localparam int ampl_lo         = 1;
  localparam int loopback_bit    = 0;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [5:0]  mode_reset     = 6'h00;
  localparam logic [2:0]  edge_reset     = 3'h6;
  localparam logic [1:0]  in_pre_reset   = 2'h0;
  localparam logic        out_pre_reset  = 1'b1;
  localparam logic [1:0]  jumbo_reset    = 2'h0;
  localparam logic [2:0]  ampl_reset     = 3'h0;
  localparam logic [1:0]  in_pre_resvd   = 2'h3;
  localparam logic [1:0]  jumbo_resvd    = 2'h3;
  localparam logic [15:0] ctl_two_mask   = 16'hF1FF;
  localparam logic [15:0] ctl_one_mask   = 16'h3F00;
  // max frame length in bytes per jumbo code
  localparam logic [15:0] len_normal     = 16'h05EE;  // 1518
  localparam logic [15:0] len_9k         = 16'h2400;  // 9216
  localparam logic [15:0] len_12k        = 16'h3000;  // 12288
  // interrupt status layout
  localparam int irq_align = 0;
  localparam int irq_mode  = 1;
  localparam int irq_w     = 2;
endpackage

// File: phy_extended_control_two.sv
// phy second extended control bank with alignment flag and pending mode
// assumes: apb master on clock; align_err_evt is a same-clock pulse
`timescale 1ns/10ps
//
// Contract
// - alignment error sticky, cleared on read
// - new mode applies only at soft reset
// - mode reads show active, not pending; the link status register at 0x4C reads back the pending mode
// - bit 12 enables reduced power
// - input preamble 00/01/10, 11 reserved
// - bit 6 output preamble, resets 1
// - jumbo code selects max frame length
// - amplitude field, resets to 000
// - bit 0 enables connector loopback
module phy_extended_control_two
  import phy_ctl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        align_err_evt,
  output logic      [5:0]  op_mode,
  output logic      [2:0]  edge_rate,
  output logic             low_power_en,
  output logic      [1:0]  in_preamble,
  output logic             out_preamble,
  output logic      [15:0] max_frame_len,
  output logic      [2:0]  tx_amplitude,
  output logic             loopback_en,
  output logic             soft_reset_pulse,
  output logic             irq
);
  import phy_ctl_pkg::*;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        wr_acc;
  logic        rd_acc;
  logic        known;
  logic [15:0] wdat;
  logic [15:0] ctl_two_r;
  logic [5:0]  pend_mode_r;
  logic [5:0]  mode_r;
  logic        align_r;
  logic [irq_w-1:0] irq_stat_r;
  logic [irq_w-1:0] irq_en_r;
  logic [31:0] rdata_nxt;
  logic        soft_rst;

  // single-cycle access: pready held high, no wait states
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign known   = (paddr == ctl_one_addr) || (paddr == ctl_two_addr)
                || (paddr == reset_addr) || (paddr == irq_stat_addr)
                || (paddr == irq_en_addr) || (paddr == irq_clr_addr)
                || (paddr == link_stat_addr);
  assign pslverr = psel && penable && !known;
  // only the low two byte lanes carry register bits
  assign wdat    = {pstrb[1] ? pwdata[15:8] : 8'h00,
                    pstrb[0] ? pwdata[7:0]  : 8'h00};
  assign soft_rst = wr_acc && (paddr == reset_addr)
                 && pstrb[1] && pwdata[soft_reset_bit];
  assign soft_reset_pulse = soft_rst;

  // ------------------------------------------------------------
  // second control register
  // ------------------------------------------------------------
  // sticky: only hardware reset restores defaults, soft reset keeps them
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_two_r <= {edge_reset, 1'b0, 3'h0, in_pre_reset, out_pre_reset,
                    jumbo_reset, ampl_reset, 1'b0};
    end
    else if (wr_acc && paddr == ctl_two_addr)
    begin
      // byte lanes merge so a partial write keeps the other byte
      ctl_two_r[15:8] <= pstrb[1] ? (wdat[15:8] & ctl_two_mask[15:8])
                                  : ctl_two_r[15:8];
      ctl_two_r[7:0]  <= pstrb[0] ? wdat[7:0] : ctl_two_r[7:0];
    end
  end

  // decoded controls
  assign edge_rate    = ctl_two_r[edge_lo +: 3];
  assign low_power_en = ctl_two_r[low_power_bit];
  assign in_preamble  = ctl_two_r[in_pre_lo +: 2];
  assign out_preamble = ctl_two_r[out_pre_bit];
  assign tx_amplitude = ctl_two_r[ampl_lo +: 3];
  assign loopback_en  = ctl_two_r[loopback_bit];

  // jumbo code to frame length; reserved code falls back to normal
  // longer lengths rely on partner clock accuracy, not on this logic
  always_comb
  begin
    case (ctl_two_r[jumbo_lo +: 2])
      2'h1:    max_frame_len = len_9k;
      2'h2:    max_frame_len = len_12k;
      default: max_frame_len = len_normal;
    endcase
  end

  // ------------------------------------------------------------
  // operating mode: pending copy and active copy
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pend_mode_r <= mode_reset;
    else if (wr_acc && paddr == ctl_one_addr && pstrb[1])
      pend_mode_r <= pwdata[mode_lo +: 6];
  end

  // a write and a soft reset never share a cycle on one apb port
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mode_r <= mode_reset;
    else if (soft_rst)
      mode_r <= pend_mode_r;
  end
  assign op_mode = mode_r;

  // ------------------------------------------------------------
  // alignment flag, clear on read
  // ------------------------------------------------------------
  // a new error in the read cycle wins, so no event is lost
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      align_r <= 1'b0;
    else if (align_err_evt)
      align_r <= 1'b1;
    else if (rd_acc && paddr == ctl_one_addr)
      align_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // set beats clear; bit 1 marks a mode change at soft reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_stat_r <= '0;
    else
    begin
      for (int i = 0; i < irq_w; i++)
      begin
        if ((i == irq_align && align_err_evt) ||
            (i == irq_mode && soft_rst && pend_mode_r != mode_r))
          irq_stat_r[i] <= 1'b1;
        else if (wr_acc && paddr == irq_clr_addr && pstrb[0] && pwdata[i])
          irq_stat_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_en_r <= '0;
    else if (wr_acc && paddr == irq_en_addr && pstrb[0])
      irq_en_r <= pwdata[irq_w-1:0];
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // reserved bits and write-only registers read as zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      ctl_one_addr:   rdata_nxt[15:0] = {2'b00, mode_r, 6'h00,
                                         align_r, 1'b0};
      ctl_two_addr:   rdata_nxt[15:0] = ctl_two_r & ctl_two_mask;
      irq_stat_addr:  rdata_nxt[irq_w-1:0] = irq_stat_r;
      irq_en_addr:    rdata_nxt[irq_w-1:0] = irq_en_r;
      link_stat_addr: rdata_nxt[5:0] = pend_mode_r;
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end
  // combinational data valid during the access phase
  assign prdata = rd_acc ? rdata_nxt : 32'h0000_0000;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  align_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    align_r && !(rd_acc && paddr == ctl_one_addr) |=> align_r)
    else $error("alignment flag dropped without read");
  align_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    rd_acc && paddr == ctl_one_addr && !align_err_evt |=> !align_r)
    else $error("alignment flag not cleared by read");
  align_set_a: assert property (@(posedge clock) disable iff (!rstn)
    align_err_evt |=> align_r)
    else $error("alignment event not flagged");
  mode_apply_a: assert property (@(posedge clock) disable iff (!rstn)
    soft_rst |=> mode_r == $past(pend_mode_r))
    else $error("mode not applied at soft reset");
  mode_stable_a: assert property (@(posedge clock) disable iff (!rstn)
    !soft_rst |=> $stable(mode_r))
    else $error("mode changed without soft reset");
  mode_read_a: assert property (@(posedge clock) disable iff (!rstn)
    rd_acc && paddr == ctl_one_addr |-> prdata[13:8] == mode_r)
    else $error("mode read shows pending value");
  jumbo_len_a: assert property (@(posedge clock) disable iff (!rstn)
    ctl_two_r[5:4] == 2'h1 |-> max_frame_len == len_9k)
    else $error("jumbo code 01 length wrong");
  resvd_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    rd_acc && paddr == ctl_two_addr |-> prdata[11:9] == 3'h0)
    else $error("reserved bits not zero");
  sticky_keep_a: assert property (@(posedge clock) disable iff (!rstn)
    soft_rst |=> $stable(ctl_two_r))
    else $error("control lost on soft reset");

  // ------------------------------------------------------------
  // checks: field writes land where the map says
  // ------------------------------------------------------------
  edge_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[1]
    |=> edge_rate == $past(pwdata[edge_lo +: 3]))
    else $error("edge rate write lost");
  power_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[1]
    |=> low_power_en == $past(pwdata[low_power_bit]))
    else $error("reduced power write lost");
  // the input preamble field straddles both byte lanes
  inpre_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[1] && pstrb[0]
    |=> in_preamble == $past(pwdata[in_pre_lo +: 2]))
    else $error("input preamble write lost");
  outpre_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[0]
    |=> out_preamble == $past(pwdata[out_pre_bit]))
    else $error("output preamble write lost");
  ampl_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[0]
    |=> tx_amplitude == $past(pwdata[ampl_lo +: 3]))
    else $error("amplitude write lost");
  loop_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_two_addr && pstrb[0]
    |=> loopback_en == $past(pwdata[loopback_bit]))
    else $error("loopback write lost");
  // a partial write must not disturb the other byte
  hi_keep_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !pstrb[1]
    |=> ctl_two_r[15:8] == $past(ctl_two_r[15:8]))
    else $error("upper control byte disturbed");
  lo_keep_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !pstrb[0]
    |=> ctl_two_r[7:0] == $past(ctl_two_r[7:0]))
    else $error("lower control byte disturbed");
  ctl_hold_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !(wr_acc && paddr == ctl_two_addr)
    |=> $stable(ctl_two_r))
    else $error("control changed without write");

  // ------------------------------------------------------------
  // checks: frame length decode
  // ------------------------------------------------------------
  jumbo_12k_a: assert property (
    @(posedge clock) disable iff (!rstn)
    ctl_two_r[jumbo_lo +: 2] == 2'h2
    |-> max_frame_len == len_12k)
    else $error("jumbo code 10 length wrong");
  jumbo_norm_a: assert property (
    @(posedge clock) disable iff (!rstn)
    ctl_two_r[jumbo_lo +: 2] == 2'h0
    |-> max_frame_len == len_normal)
    else $error("normal frame length wrong");
  jumbo_resvd_a: assert property (
    @(posedge clock) disable iff (!rstn)
    ctl_two_r[jumbo_lo +: 2] == jumbo_resvd
    |-> max_frame_len == len_normal)
    else $error("reserved jumbo code length wrong");

  // ------------------------------------------------------------
  // checks: pending mode, flag read and interrupts
  // ------------------------------------------------------------
  pend_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_acc && paddr == ctl_one_addr && pstrb[1]
    |=> pend_mode_r == $past(pwdata[mode_lo +: 6]))
    else $error("pending mode write lost");
  pend_hold_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !(wr_acc && paddr == ctl_one_addr && pstrb[1])
    |=> $stable(pend_mode_r))
    else $error("pending mode changed without write");
  pulse_src_a: assert property (
    @(posedge clock) disable iff (!rstn)
    soft_reset_pulse
    |-> wr_acc && paddr == reset_addr)
    else $error("soft reset pulse without write");
  align_read_a: assert property (
    @(posedge clock) disable iff (!rstn)
    rd_acc && paddr == ctl_one_addr
    |-> prdata[align_err_bit] == align_r)
    else $error("alignment flag read wrong");
  one_resvd_a: assert property (
    @(posedge clock) disable iff (!rstn)
    rd_acc && paddr == ctl_one_addr
    |-> prdata[15:14] == 2'h0 && prdata[7:2] == 6'h00 && !prdata[0])
    else $error("first control reserved bits not zero");
  upper_zero_a: assert property (
    @(posedge clock) disable iff (!rstn)
    rd_acc
    |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  unmapped_zero_a: assert property (
    @(posedge clock) disable iff (!rstn)
    pslverr
    |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  align_irq_a: assert property (
    @(posedge clock) disable iff (!rstn)
    align_err_evt
    |=> irq_stat_r[irq_align])
    else $error("alignment status not set");
  mode_irq_a: assert property (
    @(posedge clock) disable iff (!rstn)
    soft_rst && pend_mode_r != mode_r
    |=> irq_stat_r[irq_mode])
    else $error("mode change status not set");

  irq_level_a: assert property (@(posedge clock) disable iff (!rstn)
    irq == |(irq_stat_r & irq_en_r))
    else $error("irq level mismatch");
endmodule // phy_extended_control_two

// File: testbench.sv
// testbench: apb master driving the extended control bank
// assumes: zero-wait apb slave, mac model raises alignment pulses
`timescale 1ns/10ps
module testbench;
  import phy_ctl_pkg::*;
  logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  pstrb = 4'h3;
  logic        pready, pslverr, align_err_evt, misalign_req = 0, e;
  logic [5:0]  op_mode;
  logic [2:0]  edge_rate, tx_amplitude;
  logic [1:0]  in_preamble;
  logic [15:0] max_frame_len;
  logic        low_power_en, out_preamble, loopback_en, soft_reset_pulse;
  logic        irq;
  int          bad_count = 0, samples_checked = 0;
  always #2 clock = ~clock;
  phy_extended_control_two u_phy_extended_control_two (.clock(clock),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .align_err_evt(align_err_evt),
    .op_mode(op_mode), .edge_rate(edge_rate), .low_power_en(low_power_en),
    .in_preamble(in_preamble), .out_preamble(out_preamble),
    .max_frame_len(max_frame_len), .tx_amplitude(tx_amplitude),
    .loopback_en(loopback_en), .soft_reset_pulse(soft_reset_pulse),
    .irq(irq));
  mac_link_model u_mac_link_model (.clock(clock), .rstn(rstn),
    .misalign_req(misalign_req), .align_err_evt(align_err_evt));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic results();
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    // registered outputs update at this edge; look once they settle
    @(negedge clock);
    if (n >= 20) begin bad_count++; results(); end
  endtask
  task automatic misalign();
    @(posedge clock) misalign_req <= 1;
    @(posedge clock) misalign_req <= 0;
    @(posedge clock);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic reset_values();
    apb(0, ctl_two_addr, 0); chk(q, 32'hC040);
    chk({edge_rate, low_power_en, out_preamble}, 5'b11001);
    chk({in_preamble, tx_amplitude, loopback_en}, 6'h00);
    chk(max_frame_len, len_normal);
  endtask
  task automatic field_writes();
    logic [15:0] lens [4];
    lens = '{len_normal, len_9k, len_12k, len_normal};
    apb(1, ctl_two_addr, 32'h7F19); apb(0, ctl_two_addr, 0);
    chk(q, 32'h7119);
    chk({edge_rate, low_power_en, in_preamble}, 6'b011110);
    chk({out_preamble, tx_amplitude, loopback_en}, 5'b01001);
    for (int j = 0; j < 4; j++)
    begin
      apb(1, ctl_two_addr, 32'h7109 | (j << 4));
      chk(max_frame_len, lens[j]);
    end
    apb(1, ctl_two_addr, 32'h7119);
    apb(1, 8'h20, 32'hFFFF); chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic align_flag();
    apb(1, irq_en_addr, 0); misalign();
    chk(irq, 0);
    apb(0, irq_stat_addr, 0); chk(q[0], 1);
    apb(1, irq_en_addr, 1); chk(irq, 1);
    apb(1, irq_clr_addr, 1); @(posedge clock); chk(irq, 0);
    apb(0, ctl_one_addr, 0); chk(q[1], 1);
    apb(0, ctl_one_addr, 0); chk(q[1], 0);
  endtask
  task automatic mode_change();
    apb(1, ctl_one_addr, 32'h2A00); apb(0, ctl_one_addr, 0);
    chk(q & 32'h3F00, 0);
    chk(op_mode, 6'h00);
    apb(0, link_stat_addr, 0); chk(q & 32'h3F, 32'h2A);
    apb(1, reset_addr, 32'h8000); @(posedge clock);
    chk(op_mode, 6'h2A);
    apb(0, ctl_one_addr, 0); chk(q & 32'h3F00, 32'h2A00);
    apb(0, ctl_two_addr, 0); chk(q, 32'h7119);
    apb(0, irq_stat_addr, 0); chk(q[1], 1);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1;
    reset_values();
    field_writes();
    align_flag();
    mode_change();
    results();
  end
endmodule  // testbench
